// ---- include/aout_pkg.sv ----
// Purpose: shared constants for the analog output value selector
// Assumes: levels in millivolts for voltage types and microamps for current types
// Notes: types and encodings shared by the selector, its scaler and the bench
// Function
// R1 - nine analog output channels, each configured independently
// R2 - each channel picks its source from the available analog values
// R3 - six signal types: 0-10V, 0-20mA, 4-20mA and their inversions
// R4 - scale start maps to lower range limit, 0 V or 0/4 mA
// R5 - scale end maps to upper range limit, 10 V or 20 mA
// R6 - manual mode enable; when on, output the operator test value
// R7 - four safety values per channel, limited to 0-22 mA or 0-10.7 V
// R8 - conductivity source uses safety and scale pair of active range 1-4
// R9 - any other source always uses the first safety value
// R10 - selected binary signal activates hold; output follows hold response
// R11 - hold response: low, high, fault-low, fault-high or keep
// R12 - range error response: low, high, fault-low, fault-high, keep or safety
// R13 - high response drives the upper range limit
// R14 - fault-low drives 0 V, 0 mA, or 3.4 mA for 4-20 mA
// R15 - fault-high drives 10.7 V or 22 mA
// R16 - keep freezes the output value present when the condition began
// R17 - during sensor calibration: track, freeze or safety value, as configured
// R18 - linear interpolation between scale points; inverted types swap the ends
// R19 - precedence: manual, hold, error, calibration, then scaled output
package aout_pkg;
    localparam int N_CH = 9;
    localparam int N_SRC = 16;
    localparam int N_BIN = 16;
    localparam int N_CFG = 14;
    localparam int DAT_W = 32;
    localparam int OUT_W = 16;
    localparam int ADR_W = 10;
    localparam int CH_W = 4;
    localparam int WORD_W = 4;
    localparam int SRC_W = 4;
    localparam int TYPE_W = 3;
    localparam int SUB_W = 3;
    localparam int CAL_W = 2;
    localparam int SET_W = 2;
    localparam int BIN_IDX_W = 4;
    localparam int STAT_W = 4;
    localparam int CH_LSB = 6;
    localparam int WORD_LSB = 2;
    localparam logic [CH_W-1:0] LAST_CH = 4'h8;
    // word index inside one channel's 64-byte window
    localparam logic [WORD_W-1:0] W_CTRL = 4'h0;
    localparam logic [WORD_W-1:0] W_MANUAL = 4'h1;
    localparam logic [WORD_W-1:0] W_SAFE0 = 4'h2;
    localparam logic [WORD_W-1:0] W_START0 = 4'h6;
    localparam logic [WORD_W-1:0] W_END0 = 4'ha;
    localparam logic [WORD_W-1:0] W_OUT = 4'he;
    localparam logic [WORD_W-1:0] W_STAT = 4'hf;
    // control word field positions
    localparam int F_SRC_LSB = 0;
    localparam int F_TYPE_LSB = 4;
    localparam int F_MANUAL = 7;
    localparam int F_HOLD_LSB = 8;
    localparam int F_ERR_LSB = 11;
    localparam int F_CAL_LSB = 14;
    localparam int F_HBIT_LSB = 16;
    localparam logic [DAT_W-1:0] CFG_RESET = 32'h0000_0000;
    localparam logic [DAT_W-1:0] RD_UNMAPPED = 32'h0000_0000;
    localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;
    // drive levels
    localparam logic [OUT_W-1:0] LVL_ZERO = 16'h0000;
    localparam logic [OUT_W-1:0] LVL_V_HIGH = 16'h2710;
    localparam logic [OUT_W-1:0] LVL_V_FHIGH = 16'h29cc;
    localparam logic [OUT_W-1:0] LVL_I4_LOW = 16'h0fa0;
    localparam logic [OUT_W-1:0] LVL_I4_FLOW = 16'h0d48;
    localparam logic [OUT_W-1:0] LVL_I_HIGH = 16'h4e20;
    localparam logic [OUT_W-1:0] LVL_I_FHIGH = 16'h55f0;
    localparam logic [4:0] DIV_STEPS = 5'h10;

    typedef enum logic [TYPE_W-1:0] {
        SIG_V10 = 3'h0, SIG_I20 = 3'h1, SIG_I4_20 = 3'h2,
        SIG_V10_INV = 3'h3, SIG_I20_INV = 3'h4, SIG_I4_20_INV = 3'h5
    } sig_type_e;
    typedef enum logic [SUB_W-1:0] {
        SUB_LOW = 3'h0, SUB_HIGH = 3'h1, SUB_FAULT_LOW = 3'h2, SUB_FAULT_HIGH = 3'h3,
        SUB_KEEP = 3'h4, SUB_SAFETY = 3'h5, SUB_SCALED = 3'h6, SUB_MANUAL = 3'h7
    } subst_e;
    typedef enum logic [CAL_W-1:0] {
        CAL_MOVING = 2'h0, CAL_FROZEN = 2'h1, CAL_SAFE = 2'h2
    } cal_e;
    typedef enum logic [1:0] {
        ST_START = 2'h0, ST_WAIT = 2'h1, ST_COMMIT = 2'h2, ST_NEXT = 2'h3
    } svc_e;
endpackage : aout_pkg

// ---- hw/aout_linear_scaler.sv ----
// Purpose: sequential fraction of span for a source value between two scale points
// Assumes: one request at a time, i_start ignored while busy
// Notes: restoring division, one quotient bit per clock
`timescale 1ns/1ps
module aout_linear_scaler
    import aout_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic signed [DAT_W-1:0] i_x,
    input wire logic signed [DAT_W-1:0] i_pt_start,
    input wire logic signed [DAT_W-1:0] i_pt_end,
    input wire logic [OUT_W-1:0] i_span,
    output logic o_busy,
    output logic o_done,
    output logic [OUT_W-1:0] o_frac
);
    logic signed [DAT_W:0] n_s, d_s;
    logic [DAT_W:0] n_abs, d_abs;
    logic [48:0] rem, shifted;
    logic [DAT_W:0] dvs;
    logic [4:0] step, bit_idx;

    always_comb begin
        n_s = {i_x[DAT_W-1], i_x} - {i_pt_start[DAT_W-1], i_pt_start};
        d_s = {i_pt_end[DAT_W-1], i_pt_end} - {i_pt_start[DAT_W-1], i_pt_start};
        n_abs = n_s[DAT_W] ? -n_s : n_s;
        d_abs = d_s[DAT_W] ? -d_s : d_s;
        bit_idx = step - 5'h01;
        shifted = {16'h0000, dvs} << bit_idx;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_frac <= LVL_ZERO;
            rem <= '0;
            dvs <= '0;
            step <= '0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                o_frac <= LVL_ZERO;
                // before the start point (in the scale's own direction) the fraction is zero; see R18
                if (d_abs == '0 || n_s == '0 || n_s[DAT_W] != d_s[DAT_W]) begin
                    o_done <= 1'b1;
                end else if (n_abs >= d_abs) begin
                    o_frac <= i_span; // see R5
                    o_done <= 1'b1;
                end else begin
                    rem <= 49'(n_abs) * 49'(i_span); // see R18
                    dvs <= d_abs;
                    step <= DIV_STEPS;
                    o_busy <= 1'b1;
                end
            end else if (o_busy) begin
                if (rem >= shifted) begin
                    rem <= rem - shifted;
                    o_frac[bit_idx[3:0]] <= 1'b1;
                end
                step <= bit_idx;
                if (step == 5'h01) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end
endmodule : aout_linear_scaler

// ---- hw/analog_output_value_selector.sv ----
// Purpose: drive value selection for nine analog output channels behind a wishbone slave
// Assumes: source values, flags and binary signals come from logic on i_clk
// Notes: channels are serviced round robin; each output updates once per sweep
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module analog_output_value_selector
    import aout_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [DAT_W-1:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    input wire logic i_wb_we,
    input wire logic i_wb_stb,
    input wire logic i_wb_cyc,
    output logic [DAT_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [N_SRC*DAT_W-1:0] i_src_value,
    input wire logic [N_SRC-1:0] i_src_is_cond,
    input wire logic [N_SRC*SET_W-1:0] i_src_cond_range,
    input wire logic [N_SRC-1:0] i_src_range_err,
    input wire logic [N_SRC-1:0] i_src_calibrating,
    input wire logic [N_BIN-1:0] i_binary,
    output logic [N_CH*OUT_W-1:0] o_drive_value,
    output logic [N_CH*TYPE_W-1:0] o_signal_type
);
    logic [DAT_W-1:0] cfg [N_CH][N_CFG];
    logic [OUT_W-1:0] out_val [N_CH];
    logic [STAT_W-1:0] stat [N_CH];
    logic [CH_W-1:0] ch;
    svc_e state;

    logic [CH_W-1:0] bus_ch;
    logic [WORD_W-1:0] bus_word;
    logic bus_hit, bus_req, wr_take;
    logic [DAT_W-1:0] rd_data, wmask;

    logic [DAT_W-1:0] ctrl;
    logic [SRC_W-1:0] src_sel;
    sig_type_e sig_type;
    logic manual_on, hold_now, err_now, cal_now, cur_cond, inverted, commit;
    logic [SUB_W-1:0] hold_sel, err_sel;
    logic [CAL_W-1:0] cal_sel;
    logic [SET_W-1:0] set_idx;
    logic [OUT_W-1:0] lvl_lo, lvl_hi, lvl_flo, lvl_fhi;
    logic [OUT_W-1:0] man_clamped, safe_clamped, scaled, frac, cur_out, next_val;
    subst_e pick;
    logic div_done;

    function automatic logic [OUT_W-1:0] clamp_lvl(input logic [DAT_W-1:0] v, input logic [OUT_W-1:0] lim);
        // negative entries look huge and land on the limit, never below zero
        clamp_lvl = (v > DAT_W'(lim)) ? lim : v[OUT_W-1:0];
    endfunction : clamp_lvl

    // ---------------- wishbone slave ----------------
    assign bus_ch = i_wb_adr[CH_LSB +: CH_W];
    assign bus_word = i_wb_adr[WORD_LSB +: WORD_W];
    assign bus_hit = (bus_ch <= LAST_CH);
    assign bus_req = i_wb_cyc && i_wb_stb;
    // writes land on the edge where the master samples ack
    assign wr_take = bus_req && i_wb_we && o_wb_ack;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign wmask[gb*8 +: 8] = {8{i_wb_sel[gb]}};
        end
    endgenerate

    always_comb begin
        rd_data = RD_UNMAPPED;
        if (bus_hit) begin
            if (bus_word == W_OUT) begin
                rd_data = DAT_W'(out_val[bus_ch]);
            end else if (bus_word == W_STAT) begin
                rd_data = DAT_W'(stat[bus_ch]);
            end else begin
                rd_data = cfg[bus_ch][bus_word];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= RD_UNMAPPED;
        end else begin
            o_wb_ack <= bus_req && !o_wb_ack;
            if (bus_req && !o_wb_ack) begin
                o_wb_dat <= rd_data;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int c = 0; c < N_CH; c++) begin
                for (int w = 0; w < N_CFG; w++) begin
                    cfg[c][w] <= CFG_RESET;
                end
            end
        end else if (wr_take && bus_hit && bus_word < W_OUT) begin
            // see R1
            cfg[bus_ch][bus_word] <= (cfg[bus_ch][bus_word] & ~wmask) | (i_wb_dat & wmask);
        end
    end

    // ---------------- per channel settings ----------------
    assign ctrl = cfg[ch][W_CTRL];
    assign src_sel = ctrl[F_SRC_LSB +: SRC_W]; // see R2
    assign sig_type = sig_type_e'(ctrl[F_TYPE_LSB +: TYPE_W]);
    assign manual_on = ctrl[F_MANUAL];
    assign hold_sel = ctrl[F_HOLD_LSB +: SUB_W];
    assign err_sel = ctrl[F_ERR_LSB +: SUB_W];
    assign cal_sel = ctrl[F_CAL_LSB +: CAL_W];
    assign hold_now = i_binary[ctrl[F_HBIT_LSB +: BIN_IDX_W]]; // see R10
    assign err_now = i_src_range_err[src_sel];
    assign cal_now = i_src_calibrating[src_sel];
    assign cur_cond = i_src_is_cond[src_sel];
    // conductivity follows its measuring range, all else uses set one
    assign set_idx = cur_cond ? i_src_cond_range[src_sel*SET_W +: SET_W] : '0; // see R8 see R9
    assign commit = (state == ST_COMMIT);
    assign cur_out = out_val[ch];

    always_comb begin
        lvl_lo = LVL_ZERO;
        lvl_hi = LVL_I_HIGH;
        lvl_flo = LVL_ZERO;
        lvl_fhi = LVL_I_FHIGH;
        inverted = 1'b0;
        case (sig_type) // see R3
            SIG_V10, SIG_V10_INV: begin
                lvl_hi = LVL_V_HIGH; // see R5 see R13
                lvl_fhi = LVL_V_FHIGH; // see R15
            end
            SIG_I4_20, SIG_I4_20_INV: begin
                lvl_lo = LVL_I4_LOW; // see R4
                lvl_flo = LVL_I4_FLOW; // see R14
            end
            default: begin
            end
        endcase
        inverted = (sig_type == SIG_V10_INV) || (sig_type == SIG_I20_INV) || (sig_type == SIG_I4_20_INV);
    end

    assign man_clamped = clamp_lvl(cfg[ch][W_MANUAL], lvl_fhi); // see R6
    assign safe_clamped = clamp_lvl(cfg[ch][W_SAFE0 + set_idx], lvl_fhi); // see R7

    aout_linear_scaler u_scaler (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_start(state == ST_START),
        .i_x(i_src_value[src_sel*DAT_W +: DAT_W]),
        .i_pt_start(cfg[ch][W_START0 + set_idx]),
        .i_pt_end(cfg[ch][W_END0 + set_idx]),
        .i_span(lvl_hi - lvl_lo),
        .o_busy(),
        .o_done(div_done),
        .o_frac(frac)
    );

    // inverted types run from the top of the range down; see R18
    assign scaled = inverted ? (lvl_hi - frac) : (lvl_lo + frac);

    // one decision per channel, strongest condition first
    always_comb begin
        pick = SUB_SCALED;
        if (manual_on) begin
            pick = SUB_MANUAL; // see R19
        end else if (hold_now) begin
            pick = (hold_sel > SUB_KEEP) ? SUB_KEEP : subst_e'(hold_sel); // see R11
        end else if (err_now) begin
            pick = (err_sel > SUB_SAFETY) ? SUB_KEEP : subst_e'(err_sel); // see R12
        end else if (cal_now) begin
            case (cal_sel) // see R17
                CAL_FROZEN: pick = SUB_KEEP;
                CAL_SAFE: pick = SUB_SAFETY;
                default: pick = SUB_SCALED;
            endcase
        end
    end

    always_comb begin
        case (pick)
            SUB_LOW: next_val = lvl_lo;
            SUB_HIGH: next_val = lvl_hi; // see R13
            SUB_FAULT_LOW: next_val = lvl_flo; // see R14
            SUB_FAULT_HIGH: next_val = lvl_fhi; // see R15
            SUB_SAFETY: next_val = safe_clamped;
            SUB_SCALED: next_val = scaled;
            SUB_MANUAL: next_val = man_clamped;
            default: next_val = cur_out; // see R16
        endcase
    end

    // ---------------- channel sweep ----------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= ST_START;
            ch <= '0;
        end else begin
            case (state)
                ST_START: state <= ST_WAIT;
                ST_WAIT: begin
                    if (div_done) begin
                        state <= ST_COMMIT;
                    end
                end
                ST_COMMIT: state <= ST_NEXT;
                ST_NEXT: begin
                    ch <= (ch == LAST_CH) ? '0 : ch + 4'h1; // see R1
                    state <= ST_START;
                end
                default: state <= ST_START;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int c = 0; c < N_CH; c++) begin
                out_val[c] <= LVL_ZERO;
                stat[c] <= STAT_RESET;
            end
        end else if (commit) begin
            out_val[ch] <= next_val;
            stat[ch] <= {manual_on, hold_now, err_now, cal_now};
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < N_CH; gc++) begin : g_out
            assign o_drive_value[gc*OUT_W +: OUT_W] = out_val[gc];
            assign o_signal_type[gc*TYPE_W +: TYPE_W] = cfg[gc][W_CTRL][F_TYPE_LSB +: TYPE_W];
        end
    endgenerate

    // ---------------- assertions ----------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_start;
        state == ST_START;
    endsequence
    sequence s_commit;
        state == ST_COMMIT;
    endsequence
    sequence s_manual_commit;
        s_commit and manual_on;
    endsequence
    // a lower-priority response may only act when every stronger condition is absent
    sequence s_hold_commit;
        s_commit and (!manual_on && hold_now);
    endsequence
    sequence s_err_commit;
        s_commit and (!manual_on && !hold_now && err_now);
    endsequence
    sequence s_cal_commit;
        s_commit and (!manual_on && !hold_now && !err_now && cal_now);
    endsequence

    a_ack_single_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    a_service_bounded: assert property (s_start |-> ##[2:20] s_commit) // see R1
        else $error("channel service did not complete in time");
    a_channel_wraps: assert property (state == ST_NEXT && ch == LAST_CH |=> s_start and (ch == '0)) // see R1
        else $error("channel sweep did not wrap to channel zero");
    a_manual_wins: assert property (s_manual_commit |=> cur_out == $past(man_clamped)) // see R6
        else $error("manual value not driven");
    a_hold_fault_high: assert property (s_commit and (!manual_on && hold_now && hold_sel == SUB_FAULT_HIGH)
        |=> cur_out == $past(lvl_fhi)) // see R15
        else $error("hold fault-high level wrong");
    a_err_safety_val: assert property (s_commit and (!manual_on && !hold_now && err_now && err_sel == SUB_SAFETY)
        |=> cur_out == $past(safe_clamped)) // see R12
        else $error("error safety value not driven");
    a_keep_freezes: assert property (s_commit and (pick == SUB_KEEP) |=> $stable(cur_out)) // see R16
        else $error("keep response changed the output");
    a_cond_index: assert property (s_start and cur_cond |-> set_idx == i_src_cond_range[src_sel*SET_W +: SET_W]) // see R8
        else $error("conductivity range index not used");
    a_other_index: assert property (s_start and !cur_cond |-> set_idx == '0) // see R9
        else $error("non conductivity source not on first set");
    a_below_fault_high: assert property (s_commit |=> cur_out <= $past(lvl_fhi)) // see R7
        else $error("output above fault-high level");
    a_scaled_in_range: assert property (s_commit and (pick == SUB_SCALED)
        |=> cur_out >= $past(lvl_lo) && cur_out <= $past(lvl_hi)) // see R18
        else $error("scaled output outside signal range");
    a_hold_high_lvl: assert property (s_hold_commit and (hold_sel == SUB_HIGH)
        |=> cur_out == $past(lvl_hi)) // see R13
        else $error("hold high level wrong");
    a_hold_fault_low: assert property (s_hold_commit and (hold_sel == SUB_FAULT_LOW)
        |=> cur_out == $past(lvl_flo)) // see R14
        else $error("hold fault-low level wrong");
    a_err_low_lvl: assert property (s_err_commit and (err_sel == SUB_LOW)
        |=> cur_out == $past(lvl_lo)) // see R12
        else $error("error low level wrong");
    a_cal_safe_val: assert property (s_cal_commit and (cal_sel == CAL_SAFE)
        |=> cur_out == $past(safe_clamped)) // see R17
        else $error("calibration safety value not driven");
endmodule : analog_output_value_selector

// ---- testbench/aout_converter_model.sv ----
// Purpose: behavioural output converter fed by the value selector
// Assumes: codes in mV for voltage types, uA for current types
// Notes: only flags overdrive; the analog stage itself is not modelled
`timescale 1ns/1ps
module aout_converter_model
    import aout_pkg::*;
(
    input wire logic i_clk,
    input wire logic [N_CH*OUT_W-1:0] i_drive_value,
    input wire logic [N_CH*TYPE_W-1:0] i_signal_type,
    output logic o_over_range
);
    // a code above fault-high would push the converter past its safe output
    always_ff @(posedge i_clk) begin
        o_over_range <= 1'b0;
        for (int c = 0; c < N_CH; c++) begin
            if (i_signal_type[TYPE_W*c +: TYPE_W] inside {3'h0, 3'h3}) begin
                if (i_drive_value[OUT_W*c +: OUT_W] > LVL_V_FHIGH) o_over_range <= 1'b1;
            end else if (i_drive_value[OUT_W*c +: OUT_W] > LVL_I_FHIGH) begin
                o_over_range <= 1'b1;
            end
        end
    end
endmodule : aout_converter_model

// ---- testbench/analog_output_value_selector_tb.sv ----
// Purpose: self-checking bench for the analog output value selector
// Assumes: bus answers one cycle after a request
// Notes: waits two sweeps after each change, since outputs refresh round robin
`timescale 1ns/1ps
module analog_output_value_selector_tb;
    import aout_pkg::*;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [ADR_W-1:0] wb_adr = '0;
    logic [DAT_W-1:0] wb_dat = '0;
    logic wb_we = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_cyc = 1'b0;
    logic [DAT_W-1:0] rd_dat;
    logic wb_ack;
    logic [N_SRC*DAT_W-1:0] src_value = '0;
    logic [N_SRC-1:0] src_is_cond = '0;
    logic [N_SRC*SET_W-1:0] src_cond_range = '0;
    logic [N_SRC-1:0] src_range_err = '0;
    logic [N_SRC-1:0] src_calibrating = '0;
    logic [N_BIN-1:0] binary = '0;
    logic [N_CH*OUT_W-1:0] drive_value;
    logic [N_CH*TYPE_W-1:0] signal_type;
    logic over_range;
    int error_cnt = 0;
    int n_compared = 0;
    analog_output_value_selector analog_output_value_selector_inst (.i_clk(i_clk), .i_srst(i_srst),
        .i_wb_adr(wb_adr), .i_wb_dat(wb_dat), .i_wb_sel(4'hf), .i_wb_we(wb_we), .i_wb_stb(wb_stb),
        .i_wb_cyc(wb_cyc), .o_wb_dat(rd_dat), .o_wb_ack(wb_ack), .i_src_value(src_value),
        .i_src_is_cond(src_is_cond), .i_src_cond_range(src_cond_range), .i_src_range_err(src_range_err),
        .i_src_calibrating(src_calibrating), .i_binary(binary), .o_drive_value(drive_value),
        .o_signal_type(signal_type));
    aout_converter_model aout_converter_model_inst (.i_clk(i_clk), .i_drive_value(drive_value),
        .i_signal_type(signal_type), .o_over_range(over_range));
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    task automatic finish_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic we, input logic [3:0] ch, input logic [3:0] w,
                       input logic [DAT_W-1:0] d, output logic [DAT_W-1:0] rd);
        int n;
        n = 0;
        @(posedge i_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {ch, w, 2'b00};
        wb_dat <= d;
        do begin
            @(posedge i_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        rd = rd_dat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] ch, input logic [3:0] w, input logic [DAT_W-1:0] d);
        logic [DAT_W-1:0] x;
        bus(1'b1, ch, w, d, x);
    endtask : wr
    function automatic logic [DAT_W-1:0] ctrl(input logic [3:0] s, input logic [2:0] t, input logic m,
        input logic [2:0] h, input logic [2:0] e, input logic [1:0] c, input logic [3:0] b);
        return {12'h000, b, c, e, h, m, t, s};
    endfunction : ctrl
    task automatic settle();
        repeat (400) @(posedge i_clk);
    endtask : settle
    task automatic set_src(input int s, input int v);
        @(posedge i_clk);
        src_value[DAT_W*s +: DAT_W] <= v;
    endtask : set_src
    function automatic logic [OUT_W-1:0] drv(input int c);
        return drive_value[OUT_W*c +: OUT_W];
    endfunction : drv
    task automatic t_regs();
        logic [DAT_W-1:0] d;
        bus(1'b0, 4'h8, W_CTRL, '0, d);
        check(d, CFG_RESET);
        wr(4'h8, W_CTRL, ctrl(4'hf, 3'h5, 1'b1, 3'h4, 3'h5, 2'h2, 4'hf));
        bus(1'b0, 4'h8, W_CTRL, '0, d);
        check(d, 32'h000f_acdf);
        @(posedge i_clk);
        check(signal_type[TYPE_W*8 +: TYPE_W], 32'h5);
        wr(4'hf, W_CTRL, 32'h0000_1234);
        bus(1'b0, 4'hf, W_CTRL, '0, d);
        check(d, RD_UNMAPPED);
        wr(4'h0, W_OUT, 32'h0000_1234);
        bus(1'b0, 4'h0, W_OUT, '0, d);
        check(d, 32'h0);
    endtask : t_regs
    task automatic t_scale();
        int lo [3] = '{0, 0, 4000};
        int hi [3] = '{10000, 20000, 20000};
        int xs [3] = '{-5, 250, 1000};
        int sp, f, e;
        logic [DAT_W-1:0] d;
        wr(4'h0, W_START0, 32'h0);
        wr(4'h0, W_END0, 32'd1000);
        for (int t = 0; t < 6; t++) begin
            wr(4'h0, W_CTRL, ctrl(4'h2, 3'(t), 1'b0, 3'h0, 3'h0, 2'h0, 4'h0));
            for (int i = 0; i < 3; i++) begin
                set_src(2, xs[i]);
                settle();
                sp = hi[t % 3] - lo[t % 3];
                f = xs[i] <= 0 ? 0 : (xs[i] >= 1000 ? sp : xs[i] * sp / 1000);
                e = t < 3 ? lo[t % 3] + f : hi[t % 3] - f;
                check(drv(0), 32'(e));
            end
        end
        bus(1'b0, 4'h0, W_OUT, '0, d);
        check(d, 32'h0fa0);
    endtask : t_scale
    // kind 0 hold, 1 range error, 2 calibration; source moves while substituted
    task automatic run_sub(input int kind, input logic [2:0] code, output logic [DAT_W-1:0] seen);
        wr(4'h1, W_CTRL, ctrl(4'h3, 3'h2, 1'b0, kind == 0 ? code : 3'h0, kind == 1 ? code : 3'h0,
            kind == 2 ? code[1:0] : 2'h0, 4'h5));
        @(posedge i_clk);
        binary[5] <= (kind == 0);
        src_range_err[3] <= (kind == 1);
        src_calibrating[3] <= (kind == 2);
        settle();
        set_src(3, 75);
        settle();
        seen = drv(1);
        @(posedge i_clk);
        binary[5] <= 1'b0;
        src_range_err[3] <= 1'b0;
        src_calibrating[3] <= 1'b0;
        set_src(3, 50);
        settle();
    endtask : run_sub
    task automatic t_subst();
        logic [15:0] he [6] = '{16'h0fa0, 16'h4e20, 16'h0d48, 16'h55f0, 16'h2ee0, 16'h1b58};
        logic [15:0] ce [3] = '{16'h3e80, 16'h2ee0, 16'h1b58};
        logic [DAT_W-1:0] s;
        wr(4'h1, W_START0, 32'h0);
        wr(4'h1, W_END0, 32'd100);
        wr(4'h1, W_SAFE0, 32'd7000);
        set_src(3, 50);
        for (int k = 0; k < 2; k++) begin
            for (int c = 0; c < 5 + k; c++) begin
                run_sub(k, 3'(c), s);
                check(s, 32'(he[c]));
            end
        end
        for (int c = 0; c < 3; c++) begin
            run_sub(2, 3'(c), s);
            check(s, 32'(ce[c]));
        end
        wr(4'h1, W_SAFE0, 32'd30000);
        run_sub(1, 3'h5, s);
        check(s, 32'(LVL_I_FHIGH));
        wr(4'h1, W_SAFE0, 32'd7000);
        wr(4'h1, 4'h4, 32'd9000);
        wr(4'h1, 4'h8, 32'h0);
        wr(4'h1, 4'hc, 32'd200);
        src_is_cond[3] <= 1'b1;
        src_cond_range[7:6] <= 2'h2;
        run_sub(1, 3'h5, s);
        check(s, 32'd9000);
        check(drv(1), 32'd8000);
        src_is_cond[3] <= 1'b0;
        run_sub(1, 3'h5, s);
        check(s, 32'd7000);
    endtask : t_subst
    task automatic t_prec();
        wr(4'h1, W_MANUAL, 32'd5555);
        wr(4'h1, W_CTRL, ctrl(4'h3, 3'h2, 1'b1, 3'h1, 3'h0, 2'h2, 4'h5));
        binary[5] <= 1'b1;
        src_range_err[3] <= 1'b1;
        src_calibrating[3] <= 1'b1;
        settle();
        check(drv(1), 32'd5555);
        wr(4'h1, W_CTRL, ctrl(4'h3, 3'h2, 1'b0, 3'h1, 3'h0, 2'h2, 4'h5));
        settle();
        check(drv(1), 32'd20000);
        binary[5] <= 1'b0;
        settle();
        check(drv(1), 32'd4000);
        src_range_err[3] <= 1'b0;
        settle();
        check(drv(1), 32'd7000);
        check(over_range, 32'h0);
    endtask : t_prec
    initial begin
        repeat (16) @(posedge i_clk);
        i_srst <= 1'b0;
        t_regs();
        t_scale();
        t_subst();
        t_prec();
        finish_test();
    end
    // whole run needs about 30000 cycles
    initial begin
        repeat (80000) @(posedge i_clk);
        error_cnt++;
        finish_test();
    end
endmodule : analog_output_value_selector_tb
